/* include/core_pkg.sv */
// Types shared by the instruction sequencer files
package core_pkg;

	// ===========================================================
	// Opcodes, in instruction word order
	typedef enum logic [4:0] {
		op_nop,
		op_transfer_m_to_acc,
		op_transfer_acc_to_m,
		op_transfer_imm_to_acc,
		op_add,
		op_add_carry,
		op_sub,
		op_sub_borrow,
		op_sub_imm,
		op_add_one_in_place,
		op_add_one_to_acc,
		op_subtract_one_in_place,
		op_subtract_one_to_acc,
		op_and,
		op_or,
		op_xor,
		op_complement_instr,
		op_rotate_right_plain,
		op_rotate_left_plain,
		op_rotate_right_via_carry,
		op_rotate_left_via_carry,
		op_bit_set,
		op_bit_clear,
		op_skip_if_zero,
		op_skip_if_bit_zero,
		op_skip_if_bit_one,
		op_unconditional_branch,
		op_call_routine,
		op_back_from_routine,
		op_back_from_interrupt,
		op_table_read,
		op_clear_m
	} op_t;

	// ===========================================================
	// Instruction cycle kind
	typedef enum logic {
		st_run,
		st_extra
	} seq_state_t;

endpackage

/* include/instruction_cycle_timing_cfg.svh */
// Constants for the instruction sequencer and its datapath
`ifndef INSTRUCTION_CYCLE_TIMING_CFG_SVH
`define INSTRUCTION_CYCLE_TIMING_CFG_SVH

// ===========================================================
// Timing
`define CLOCKS_PER_INSTR 4
`define FETCH_PHASE 2

// ===========================================================
// Instruction word layout
`define OP_MSB 15
`define OP_LSB 11
`define BIT_MSB 10
`define BIT_LSB 8
`define ARG_MSB 7
`define ARG_LSB 0

// ===========================================================
// Addresses and reset values
`define PROG_COUNTER_LOW_ADDR 8'h06
`define TABLE_PAGE 3'h7
`define PC_RESET 11'h000
`define ACC_RESET 8'h00
`define STACK_DEPTH 4

`endif

/* rtl/data_ram.sv */
// Data memory with registered read data
`timescale 1ns/1ps

module data_ram #(
	parameter int WIDTH = 8,
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_resetn,
	// Write port
	input wire logic i_we,
	input wire logic [ADDR_W-1:0] i_waddr,
	input wire logic [WIDTH-1:0] i_wdata,
	// Read port
	input wire logic [ADDR_W-1:0] i_raddr,
	output logic [WIDTH-1:0] o_rdata
);
	logic [WIDTH-1:0] mem [2**ADDR_W];
	logic [WIDTH-1:0] rdata_r;

	always_ff @(posedge i_clock) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= mem[i_raddr];
		end
	end

	assign o_rdata = rdata_r;
endmodule

/* rtl/instruction_cycle_timing.sv */
// Four-phase instruction sequencer with 8-bit accumulator datapath
`timescale 1ns/1ps
`include "instruction_cycle_timing_cfg.svh"

// What this block does
// RQ1: Each instruction cycle is four clock cycles; everything steps per cycle.
// RQ2: Most instructions take one cycle; branch, call and table read take two.
// RQ3: Jump, call, return and interrupt return add one instruction cycle.
// RQ4: Writing the program counter low byte jumps there and adds a cycle.
// RQ5: A skip taken adds one cycle; no skip takes one cycle.
// RQ6: Conditional skips test a byte or a bit, then run or skip next.
// RQ7: Call saves the next address for return; a jump saves nothing.
// RQ8: Moves: memory to accumulator, accumulator to memory, immediate to it.
// RQ9: Add carries above 255, subtract borrows below 0, chainable.
// RQ10: Increment and decrement change by one, to memory or accumulator.
// RQ11: Logical operations use the accumulator as one operand.
// RQ12: Logical operations set the zero flag on a zero result.
// RQ13: Rotates move one bit; carry variants swap the edge bit with carry.
// RQ14: Bit set and clear read, change one bit, write the byte back.
// RQ15: Table read fetches a program memory word; low byte to data memory, high byte to o_table_high.
// RQ16: Interrupt return sets the global interrupt enable; plain return not.
// RQ17: Data is eight bits wide; bit operands select bit 0 to 7.
module instruction_cycle_timing #(
	parameter int PC_W = 11,
	parameter int STACK_DEPTH = `STACK_DEPTH
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_resetn,
	// Program memory
	output logic [PC_W-1:0] o_prog_addr,
	input wire logic [15:0] i_prog_data,
	// Interrupt enable
	input wire logic i_irq_taken,
	output logic o_global_irq_enable,
	// Core state
	output logic [7:0] o_acc,
	output logic [7:0] o_table_high,
	output logic o_carry,
	output logic o_zero,
	output logic o_cycle_start,
	output core_pkg::seq_state_t o_seq_state
);
	import core_pkg::*;

	localparam int PH_W = $clog2(`CLOCKS_PER_INSTR);
	localparam logic [PH_W-1:0] PH_LAST = PH_W'(`CLOCKS_PER_INSTR - 1);
	localparam logic [PH_W-1:0] PH_FETCH = PH_W'(`FETCH_PHASE);
	localparam int SP_W = $clog2(STACK_DEPTH);

	logic [PH_W-1:0] phase_r;
	seq_state_t state_r;
	logic [PC_W-1:0] pc_r, pc_nxt, prog_addr_r;
	logic [PC_W-1:0] stack_r [STACK_DEPTH];
	logic [SP_W-1:0] sp_r;
	logic [15:0] instr_r;
	logic [7:0] acc_r, acc_nxt, table_high_r, result, mem_val, bit_mask;
	logic carry_r, carry_nxt, zero_r, zero_nxt, irq_en_r, cycle_start_r;
	logic exec, wr_m, skip, extra, table_wr, arith, invert, cin;
	logic [7:0] arith_b;
	logic [8:0] sum9;
	logic ram_we;
	logic [7:0] ram_wdata, ram_rdata;
	op_t op;
	logic [2:0] bit_sel;
	logic [7:0] operand;

	assign op = op_t'(instr_r[`OP_MSB:`OP_LSB]);
	assign bit_sel = instr_r[`BIT_MSB:`BIT_LSB];
	assign operand = instr_r[`ARG_MSB:`ARG_LSB];
	assign exec = (state_r == st_run) && (phase_r == PH_LAST);
	assign bit_mask = 8'h01 << bit_sel; // RQ17
	assign mem_val = (operand == `PROG_COUNTER_LOW_ADDR) ? pc_r[7:0] : ram_rdata;

	// ===========================================================
	// Datapath
	always_comb begin
		acc_nxt = acc_r;
		carry_nxt = carry_r;
		zero_nxt = zero_r;
		result = 8'h00;
		wr_m = 1'b0;
		skip = 1'b0;
		extra = 1'b0;
		arith = 1'b0;
		invert = 1'b0;
		cin = 1'b0;
		arith_b = mem_val;
		pc_nxt = pc_r + PC_W'(1);
		unique case (op)
			op_nop: begin
			end
			op_transfer_m_to_acc: acc_nxt = mem_val; // RQ8
			op_transfer_acc_to_m: begin
				result = acc_r; // RQ8
				wr_m = 1'b1;
			end
			op_transfer_imm_to_acc: acc_nxt = operand; // RQ8
			op_add: arith = 1'b1;
			op_add_carry: begin
				arith = 1'b1;
				cin = carry_r;
			end
			op_sub: begin
				arith = 1'b1;
				invert = 1'b1;
				cin = 1'b1;
			end
			op_sub_borrow: begin
				arith = 1'b1;
				invert = 1'b1;
				cin = carry_r;
			end
			op_sub_imm: begin
				arith = 1'b1;
				invert = 1'b1;
				cin = 1'b1;
				arith_b = operand;
			end
			op_add_one_in_place, op_subtract_one_in_place: begin
				result = (op == op_add_one_in_place) ? mem_val + 8'h01
					: mem_val - 8'h01; // RQ10
				wr_m = 1'b1;
				zero_nxt = (result == 8'h00);
			end
			op_add_one_to_acc, op_subtract_one_to_acc: begin
				acc_nxt = (op == op_add_one_to_acc) ? mem_val + 8'h01
					: mem_val - 8'h01; // RQ10
				zero_nxt = (acc_nxt == 8'h00);
			end
			op_and, op_or, op_xor: begin
				acc_nxt = (op == op_and) ? acc_r & mem_val // RQ11
					: (op == op_or) ? acc_r | mem_val : acc_r ^ mem_val;
				zero_nxt = (acc_nxt == 8'h00); // RQ12
			end
			op_complement_instr: begin
				result = ~mem_val;
				wr_m = 1'b1;
				zero_nxt = (result == 8'h00);
			end
			op_rotate_right_plain: begin
				result = {mem_val[0], mem_val[7:1]}; // RQ13
				wr_m = 1'b1;
			end
			op_rotate_left_plain: begin
				result = {mem_val[6:0], mem_val[7]}; // RQ13
				wr_m = 1'b1;
			end
			op_rotate_right_via_carry: begin
				result = {carry_r, mem_val[7:1]}; // RQ13
				carry_nxt = mem_val[0];
				wr_m = 1'b1;
			end
			op_rotate_left_via_carry: begin
				result = {mem_val[6:0], carry_r}; // RQ13
				carry_nxt = mem_val[7];
				wr_m = 1'b1;
			end
			op_bit_set: begin
				result = mem_val | bit_mask; // RQ14
				wr_m = 1'b1;
			end
			op_bit_clear: begin
				result = mem_val & ~bit_mask; // RQ14
				wr_m = 1'b1;
			end
			op_skip_if_zero: skip = (mem_val == 8'h00); // RQ6
			op_skip_if_bit_zero: skip = ~mem_val[bit_sel]; // RQ6
			op_skip_if_bit_one: skip = mem_val[bit_sel]; // RQ6
			op_unconditional_branch, op_call_routine: begin
				pc_nxt = PC_W'({bit_sel, operand}); // RQ3
				extra = 1'b1;
			end
			op_back_from_routine, op_back_from_interrupt: begin
				pc_nxt = stack_r[sp_r - SP_W'(1)]; // RQ7
				extra = 1'b1; // RQ3
			end
			op_table_read: extra = 1'b1; // RQ2
			op_clear_m: wr_m = 1'b1;
		endcase
		sum9 = {1'b0, acc_r} + {1'b0, invert ? ~arith_b : arith_b}
			+ {8'h00, cin};
		if (arith) begin
			acc_nxt = sum9[7:0]; // RQ9
			carry_nxt = sum9[8]; // RQ9
			zero_nxt = (sum9[7:0] == 8'h00);
		end
		if (wr_m && operand == `PROG_COUNTER_LOW_ADDR) begin
			pc_nxt = {pc_r[PC_W-1:8], result}; // RQ4
			extra = 1'b1;
		end
		if (skip) begin
			pc_nxt = pc_r + PC_W'(2); // RQ5
			extra = 1'b1;
		end
	end

	// ===========================================================
	// Phase and cycle kind
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			phase_r <= '0;
			cycle_start_r <= 1'b0;
		end else begin
			phase_r <= (phase_r == PH_LAST) ? '0 : phase_r + PH_W'(1); // RQ1
			cycle_start_r <= (phase_r == PH_LAST);
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			state_r <= st_run;
		end else if (exec) begin
			state_r <= extra ? st_extra : st_run; // RQ2
		end else if (phase_r == PH_LAST) begin
			state_r <= st_run;
		end
	end

	// ===========================================================
	// Fetch and table read
	assign table_wr = (state_r == st_extra) && (op == op_table_read)
		&& (phase_r == PH_FETCH);

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			prog_addr_r <= `PC_RESET;
			instr_r <= 16'h0000;
			table_high_r <= 8'h00;
		end else begin
			if (phase_r == '0) begin
				prog_addr_r <= (state_r == st_extra && op == op_table_read)
					? PC_W'({`TABLE_PAGE, acc_r}) : pc_r; // RQ15
			end
			if (phase_r == PH_FETCH && state_r == st_run) begin
				instr_r <= i_prog_data;
			end
			if (table_wr) begin
				table_high_r <= i_prog_data[15:8]; // RQ15
			end
		end
	end

	// ===========================================================
	// Execute state
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			pc_r <= `PC_RESET;
			acc_r <= `ACC_RESET;
			carry_r <= 1'b0;
			zero_r <= 1'b0;
		end else if (exec) begin
			pc_r <= pc_nxt;
			acc_r <= acc_nxt;
			carry_r <= carry_nxt;
			zero_r <= zero_nxt;
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			irq_en_r <= 1'b0;
		end else if (exec && op == op_back_from_interrupt) begin
			irq_en_r <= 1'b1; // RQ16
		end else if (i_irq_taken) begin
			irq_en_r <= 1'b0;
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			sp_r <= '0;
			for (int i = 0; i < STACK_DEPTH; i++) begin
				stack_r[i] <= '0;
			end
		end else if (exec && op == op_call_routine) begin
			stack_r[sp_r] <= pc_r + PC_W'(1); // RQ7
			sp_r <= sp_r + SP_W'(1);
		end else if (exec && (op == op_back_from_routine
				|| op == op_back_from_interrupt)) begin
			sp_r <= sp_r - SP_W'(1);
		end
	end

	// ===========================================================
	// Data memory
	assign ram_we = (exec && wr_m && operand != `PROG_COUNTER_LOW_ADDR)
		|| table_wr; // RQ14
	assign ram_wdata = table_wr ? i_prog_data[7:0] : result;

	data_ram #(
		.WIDTH(8),
		.ADDR_W(8)
	) u_ram (
		.i_clock(i_clock),
		.i_resetn(i_resetn),
		.i_we(ram_we),
		.i_waddr(operand),
		.i_wdata(ram_wdata),
		.i_raddr(i_prog_data[`ARG_MSB:`ARG_LSB]),
		.o_rdata(ram_rdata)
	);

	assign o_prog_addr = prog_addr_r;
	assign o_global_irq_enable = irq_en_r;
	assign o_acc = acc_r;
	assign o_table_high = table_high_r;
	assign o_carry = carry_r;
	assign o_zero = zero_r;
	assign o_cycle_start = cycle_start_r;
	assign o_seq_state = state_r;

	// ===========================================================
	// Checks
	property p_phase_walk;
		@(posedge i_clock) disable iff (!i_resetn)
		phase_r == PH_LAST |=> phase_r == '0 ##1 phase_r == PH_W'(1);
	endproperty
	a_phase_walk: assert property (p_phase_walk) // RQ1
		else $error("phase did not wrap after four clocks");

	property p_branch_extra;
		@(posedge i_clock) disable iff (!i_resetn)
		exec && op == op_unconditional_branch
			|=> state_r == st_extra [*4] ##1 state_r == st_run;
	endproperty
	a_branch_extra: assert property (p_branch_extra) // RQ3
		else $error("branch did not take one extra cycle");

	property p_low_byte_jump;
		@(posedge i_clock) disable iff (!i_resetn)
		exec && operand == `PROG_COUNTER_LOW_ADDR
			&& op inside {op_clear_m, op_transfer_acc_to_m}
			|=> state_r == st_extra && pc_r[7:0]
			== ($past(op) == op_clear_m ? 8'h00 : $past(acc_r));
	endproperty
	a_low_byte_jump: assert property (p_low_byte_jump) // RQ4
		else $error("low byte write did not jump");

	property p_skip_taken;
		@(posedge i_clock) disable iff (!i_resetn)
		exec && op == op_skip_if_zero && mem_val == 8'h00
			|=> pc_r == PC_W'($past(pc_r) + PC_W'(2)) && state_r == st_extra;
	endproperty
	a_skip_taken: assert property (p_skip_taken) // RQ5
		else $error("taken skip wrong");

	property p_call_saves;
		@(posedge i_clock) disable iff (!i_resetn)
		exec && op == op_call_routine
			|=> stack_r[$past(sp_r)] == PC_W'($past(pc_r) + PC_W'(1));
	endproperty
	a_call_saves: assert property (p_call_saves) // RQ7
		else $error("call saved wrong return point");

	property p_add_carry_out;
		@(posedge i_clock) disable iff (!i_resetn)
		exec && op == op_add |=> {carry_r, acc_r}
			== 9'({1'b0, $past(acc_r)} + {1'b0, $past(mem_val)});
	endproperty
	a_add_carry_out: assert property (p_add_carry_out) // RQ9
		else $error("add result or carry wrong");

	property p_step_down_acc;
		@(posedge i_clock) disable iff (!i_resetn)
		exec && op == op_subtract_one_to_acc
			|=> acc_r == 8'($past(mem_val) - 8'h01);
	endproperty
	a_step_down_acc: assert property (p_step_down_acc) // RQ10
		else $error("decrement to accumulator wrong");

	property p_logic_zero;
		@(posedge i_clock) disable iff (!i_resetn)
		exec && op inside {op_and, op_or, op_xor}
			|=> zero_r == (acc_r == 8'h00);
	endproperty
	a_logic_zero: assert property (p_logic_zero) // RQ12
		else $error("zero flag wrong after logic op");

	property p_rotate_carry;
		@(posedge i_clock) disable iff (!i_resetn)
		exec && op == op_rotate_right_via_carry
			|=> carry_r == $past(mem_val[0]);
	endproperty
	a_rotate_carry: assert property (p_rotate_carry) // RQ13
		else $error("rotate did not move bit into carry");

	property p_bit_set_only;
		@(posedge i_clock) disable iff (!i_resetn)
		exec && op == op_bit_set && operand != `PROG_COUNTER_LOW_ADDR
			|-> ram_we && ram_wdata[bit_sel]
			&& ((ram_wdata ^ mem_val) & ~bit_mask) == 8'h00;
	endproperty
	a_bit_set_only: assert property (p_bit_set_only) // RQ14
		else $error("bit set touched other bits");

	property p_irq_return;
		@(posedge i_clock) disable iff (!i_resetn)
		exec && op == op_back_from_interrupt |=> irq_en_r;
	endproperty
	a_irq_return: assert property (p_irq_return) // RQ16
		else $error("interrupt return left enable low");
endmodule

/* sim/instruction_cycle_timing_tb.sv */
// Self-checking bench for the four-phase instruction sequencer
`timescale 1ns/1ps

module instruction_cycle_timing_tb;
	import core_pkg::*;

	// ===========================================================
	// Signals
	logic i_clock;
	logic i_resetn;
	logic i_irq_taken;
	logic [15:0] i_prog_data;
	logic [10:0] o_prog_addr;
	logic o_global_irq_enable;
	logic [7:0] o_acc;
	logic [7:0] o_table_high;
	logic o_carry;
	logic o_zero;
	logic o_cycle_start;
	seq_state_t o_seq_state;
	logic [15:0] rom [0:2047];
	int wp;
	int bad_count;
	int samples_checked;

	instruction_cycle_timing i_dut (
		.i_clock(i_clock),
		.i_resetn(i_resetn),
		.o_prog_addr(o_prog_addr),
		.i_prog_data(i_prog_data),
		.i_irq_taken(i_irq_taken),
		.o_global_irq_enable(o_global_irq_enable),
		.o_acc(o_acc),
		.o_table_high(o_table_high),
		.o_carry(o_carry),
		.o_zero(o_zero),
		.o_cycle_start(o_cycle_start),
		.o_seq_state(o_seq_state)
	);

	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end

	// Program memory answers the current address at each falling edge
	always @(negedge i_clock) begin
		i_prog_data <= rom[o_prog_addr];
	end

	// ===========================================================
	// Helpers
	task automatic final_report();
		if (bad_count == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Holds the core in reset and fills program memory with no-ops
	task automatic load();
		@(negedge i_clock);
		i_resetn = 1'b0;
		for (int k = 0; k < 2048; k++) begin
			rom[k] = 16'h0000;
		end
		wp = 0;
	endtask

	// Word layout: opcode, then bit or page, then address or data
	task automatic e(input op_t op, input logic [10:0] arg);
		rom[wp] = {op, arg};
		wp++;
	endtask

	task automatic go();
		repeat (10) @(negedge i_clock);
		i_resetn = 1'b1;
	endtask

	// Counts clocks until the address shows up and compares the count
	task automatic run_to(input logic [10:0] a, input int n);
		int cnt;
		cnt = 0;
		do begin
			@(negedge i_clock);
			cnt++;
		end while (o_prog_addr !== a && cnt < 1000);
		if (o_prog_addr !== a) begin
			bad_count++;
			$display("BAD %0t seen %h expected %h", $time, o_prog_addr, a);
			final_report();
		end else begin
			check(8'(cnt), 8'(n));
		end
	endtask

	// ===========================================================
	// Scenarios
	task automatic arith_scenario();
		load();
		e(op_transfer_imm_to_acc, 11'h0f0);
		e(op_transfer_acc_to_m, 11'h010);
		e(op_transfer_imm_to_acc, 11'h020);
		e(op_add, 11'h010);
		e(op_add_carry, 11'h010);
		e(op_sub, 11'h010);
		e(op_sub_borrow, 11'h010);
		e(op_sub_imm, 11'h020);
		e(op_transfer_m_to_acc, 11'h010);
		go();
		run_to(11'h005, 21);
		check(o_acc, 8'h01);
		check(8'(o_carry), 8'h01);
		run_to(11'h006, 4);
		check(o_acc, 8'h11);
		check(8'(o_carry), 8'h00);
		run_to(11'h009, 12);
		check(o_acc, 8'hf0);
		check(8'(o_carry), 8'h01);
		check(8'(o_zero), 8'h01);
	endtask

	task automatic incdec_logic_scenario();
		load();
		e(op_transfer_imm_to_acc, 11'h0ff);
		e(op_transfer_acc_to_m, 11'h011);
		e(op_add_one_in_place, 11'h011);
		e(op_subtract_one_to_acc, 11'h011);
		e(op_add_one_to_acc, 11'h011);
		e(op_subtract_one_in_place, 11'h011);
		e(op_transfer_m_to_acc, 11'h011);
		e(op_transfer_imm_to_acc, 11'h05a);
		e(op_transfer_acc_to_m, 11'h012);
		e(op_transfer_imm_to_acc, 11'h0a5);
		e(op_and, 11'h012);
		e(op_or, 11'h012);
		e(op_xor, 11'h012);
		e(op_complement_instr, 11'h012);
		e(op_transfer_m_to_acc, 11'h012);
		go();
		run_to(11'h004, 17);
		check(o_acc, 8'hff);
		check(8'(o_zero), 8'h00);
		run_to(11'h005, 4);
		check(o_acc, 8'h01);
		run_to(11'h007, 8);
		check(o_acc, 8'hff);
		run_to(11'h00b, 16);
		check(o_acc, 8'h00);
		check(8'(o_zero), 8'h01);
		run_to(11'h00c, 4);
		check(o_acc, 8'h5a);
		check(8'(o_zero), 8'h00);
		run_to(11'h00d, 4);
		check(o_acc, 8'h00);
		check(8'(o_zero), 8'h01);
		run_to(11'h00f, 8);
		check(o_acc, 8'ha5);
		check(8'(o_zero), 8'h00);
	endtask

	task automatic rotate_scenario();
		load();
		e(op_transfer_imm_to_acc, 11'h081);
		e(op_transfer_acc_to_m, 11'h013);
		e(op_sub_imm, 11'h0ff);
		e(op_rotate_left_via_carry, 11'h013);
		e(op_transfer_m_to_acc, 11'h013);
		e(op_rotate_right_via_carry, 11'h013);
		e(op_transfer_m_to_acc, 11'h013);
		e(op_rotate_left_plain, 11'h013);
		e(op_transfer_m_to_acc, 11'h013);
		e(op_rotate_right_plain, 11'h013);
		e(op_transfer_m_to_acc, 11'h013);
		go();
		run_to(11'h005, 21);
		check(o_acc, 8'h02);
		check(8'(o_carry), 8'h01);
		run_to(11'h007, 8);
		check(o_acc, 8'h81);
		check(8'(o_carry), 8'h00);
		run_to(11'h009, 8);
		check(o_acc, 8'h03);
		check(8'(o_carry), 8'h00);
		run_to(11'h00b, 8);
		check(o_acc, 8'h81);
	endtask

	task automatic bit_skip_scenario();
		load();
		e(op_transfer_imm_to_acc, 11'h000);
		e(op_transfer_acc_to_m, 11'h014);
		e(op_bit_set, 11'h714);
		e(op_bit_set, 11'h014);
		e(op_bit_clear, 11'h714);
		e(op_transfer_m_to_acc, 11'h014);
		e(op_skip_if_bit_one, 11'h014);
		e(op_transfer_imm_to_acc, 11'h0ee);
		e(op_skip_if_bit_zero, 11'h014);
		e(op_transfer_imm_to_acc, 11'h03c);
		e(op_skip_if_zero, 11'h014);
		e(op_bit_clear, 11'h014);
		e(op_skip_if_zero, 11'h014);
		e(op_transfer_imm_to_acc, 11'h0ee);
		e(op_skip_if_bit_zero, 11'h314);
		e(op_transfer_imm_to_acc, 11'h0ee);
		e(op_skip_if_bit_one, 11'h314);
		go();
		run_to(11'h006, 25);
		check(o_acc, 8'h01);
		run_to(11'h00a, 16);
		check(o_acc, 8'h3c);
		run_to(11'h011, 28);
		check(o_acc, 8'h3c);
	endtask

	task automatic branch_scenario();
		load();
		e(op_unconditional_branch, 11'h100);
		wp = 32'h100;
		e(op_transfer_imm_to_acc, 11'h011);
		e(op_call_routine, 11'h200);
		e(op_nop, 11'h000);
		e(op_call_routine, 11'h300);
		e(op_nop, 11'h000);
		e(op_transfer_imm_to_acc, 11'h008);
		e(op_transfer_acc_to_m, 11'h006);
		e(op_transfer_imm_to_acc, 11'h0ee);
		e(op_transfer_imm_to_acc, 11'h044);
		wp = 32'h200;
		e(op_transfer_imm_to_acc, 11'h022);
		e(op_back_from_routine, 11'h000);
		wp = 32'h300;
		e(op_back_from_interrupt, 11'h000);
		go();
		run_to(11'h103, 37);
		check(o_acc, 8'h22);
		check(8'(o_global_irq_enable), 8'h00);
		run_to(11'h105, 20);
		check(8'(o_global_irq_enable), 8'h01);
		run_to(11'h109, 16);
		check(o_acc, 8'h44);
		@(negedge i_clock);
		i_irq_taken = 1'b1;
		@(negedge i_clock);
		i_irq_taken = 1'b0;
		check(8'(o_global_irq_enable), 8'h00);
	endtask

	task automatic table_scenario();
		load();
		rom[11'h7c5] = 16'hbeef;
		e(op_transfer_imm_to_acc, 11'h0c5);
		e(op_table_read, 11'h016);
		e(op_transfer_m_to_acc, 11'h016);
		e(op_clear_m, 11'h016);
		e(op_transfer_m_to_acc, 11'h016);
		go();
		run_to(11'h7c5, 9);
		check(8'(o_seq_state), 8'(st_extra));
		check(8'(o_cycle_start), 8'h00);
		run_to(11'h003, 8);
		check(o_acc, 8'hef);
		check(o_table_high, 8'hbe);
		repeat (3) @(negedge i_clock);
		check(8'(o_cycle_start), 8'h01);
		check(8'(o_seq_state), 8'(st_run));
		run_to(11'h005, 5);
		check(o_acc, 8'h00);
	endtask

	// ===========================================================
	// Main sequence
	initial begin
		i_resetn = 1'b0;
		i_irq_taken = 1'b0;
		bad_count = 0;
		samples_checked = 0;
		arith_scenario();
		incdec_logic_scenario();
		rotate_scenario();
		bit_skip_scenario();
		branch_scenario();
		table_scenario();
		final_report();
	end

endmodule
